// *** i2c_ctrl_pkg.sv ***
/*
  Package for the two-wire bus controller: register offsets, field positions,
  reset values, engine states and bit timing. Assumes a 40 MHz system clock.
*/
`default_nettype none

package i2c_ctrl_pkg;

  // ----------------------------------------------------------------------
  // register map (word index on the register port)
  // ----------------------------------------------------------------------
  localparam int          REG_AW       = 2;
  localparam logic [1:0]  OFS_CONTROL  = 2'h0;
  localparam logic [1:0]  OFS_STATUS   = 2'h1;
  localparam logic [1:0]  OFS_DATA     = 2'h2;
  localparam logic [1:0]  OFS_SLV_ADDR = 2'h3;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTL_EN   = 7;
  localparam int CTL_IE   = 6;
  localparam int CTL_MST  = 5;
  localparam int CTL_TX   = 4;
  localparam int CTL_ACK_SUPPRESS = 3;
  localparam int CTL_REPEAT_START_REQUEST = 2;
  localparam int ST_TCF   = 7;
  localparam int ST_ADDRESSED_AS_SLAVE  = 6;
  localparam int ST_BUSY  = 5;
  localparam int ST_ARBITRATION_LOST  = 4;
  localparam int ST_SRW   = 2;
  localparam int ST_IF    = 1;
  localparam int ST_RECEIVED_ACK  = 0;
  localparam int SA_GCEN  = 0;

  // ----------------------------------------------------------------------
  // reset values, ack and last bit indices, general-call address
  // ----------------------------------------------------------------------
  localparam logic [7:0] RST_CONTROL  = 8'h00;
  localparam logic       RST_TCF      = 1'b1;
  localparam logic [7:0] RST_SLV_ADDR = 8'h00;
  localparam logic [3:0] BIT_ACK      = 4'h8;
  localparam logic [3:0] BIT_LAST     = 4'h7;
  localparam logic [7:0] GEN_CALL     = 8'h00;

  // ----------------------------------------------------------------------
  // timing: half a bus clock period
  // ----------------------------------------------------------------------
  localparam int         CLK_PERIOD_PS = 25000;
  localparam int         SCL_HALF_NS   = 5000;
  localparam int         SCL_HALF_CYC  = (SCL_HALF_NS * 1000) / CLK_PERIOD_PS;
  localparam logic [7:0] HALF_RELOAD   = 8'(SCL_HALF_CYC - 1);

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h0,
    ST_MSTART = 4'h1,
    ST_MLOW   = 4'h2,
    ST_MHIGH  = 4'h3,
    ST_MHOLD  = 4'h4,
    ST_MSTOP1 = 4'h5,
    ST_MSTOP2 = 4'h6,
    ST_MRS1   = 4'h7,
    ST_MRS2   = 4'h8,
    ST_SSHIFT = 4'h9,
    ST_SHOLD  = 4'hA
  } eng_state_t;

endpackage : i2c_ctrl_pkg

`default_nettype wire

// *** i2c_pin_sync.sv ***
/*
  Two-stage synchroniser for the bus lines. Assumes the inputs are
  asynchronous pins; only the second stage leaves this module.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_pin_sync (
  input  wire logic       clk_sys, // system clock
  input  wire logic       sys_rst, // synchronous reset, high
  input  wire logic [1:0] pin_in,  // raw line levels
  output logic      [1:0] pin_out  // synchronised levels
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_q <= 2'h3;
      sync_q <= 2'h3;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end

  assign pin_out = sync_q;

endmodule : i2c_pin_sync

`default_nettype wire

// *** i2c_line_monitor.sv ***
/*
  Watches the synchronised bus lines: clock edges, START, STOP and bus busy.
  Assumes its inputs are already on the system clock.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_line_monitor (
  input  wire logic clk_sys,   // system clock
  input  wire logic sys_rst,   // synchronous reset, high
  input  wire logic scl_s,     // synchronised clock line
  input  wire logic sda_s,     // synchronised data line
  output logic      scl_rise,  // clock line rose
  output logic      scl_fall,  // clock line fell
  output logic      start_det, // start or repeated start seen
  output logic      stop_det,  // stop seen
  output logic      bus_busy   // bus between start and stop
);

  logic scl_p_q;
  logic sda_p_q;
  logic busy_q;

  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det  = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign bus_busy  = busy_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      busy_q  <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      if (start_det)
        busy_q <= 1'b1;
      else if (stop_det)
        busy_q <= 1'b0;
    end
  end

endmodule : i2c_line_monitor

`default_nettype wire

// *** i2c_master_slave_controller.sv ***
/*
  Two-wire bus controller, master or addressed slave, byte oriented, with a
  control, status and data register on a plain register port.
  Assumes open-drain pads outside: an enable high pulls the line low.
*/
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module i2c_master_slave_controller (
  input  wire logic                           clk_sys,  // system clock
  input  wire logic                           sys_rst,  // synchronous reset, high
  input  wire logic [i2c_ctrl_pkg::REG_AW-1:0] reg_addr, // register index
  input  wire logic [7:0]                     reg_wdata, // write data
  input  wire logic                           reg_wr,   // write strobe
  input  wire logic                           reg_rd,   // read strobe
  output logic      [7:0]                     reg_rdata, // read data, next cycle
  input  wire logic                           scl_in,   // clock line level
  output logic                                scl_out,  // clock line drive value
  output logic                                scl_oe,   // pull clock line low
  input  wire logic                           sda_in,   // data line level
  output logic                                sda_out,  // data line drive value
  output logic                                sda_oe,   // pull data line low
  output logic                                irq       // interrupt request
);
  import i2c_ctrl_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    eng_state_t st;
    logic [7:0] tmr;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic       addr_ph;
    logic       mst_prev;
    logic       en;
    logic       ie;
    logic       master_select;
    logic       tx;
    logic       ack_suppress;
    logic [7:0] sadr;
    logic       transfer_complete_flag;
    logic       addressed_as_slave;
    logic       arbitration_lost;
    logic       slave_read_write;
    logic       interrupt_pending_flag;
    logic       received_ack;
    logic [7:0] rxd;
    logic [7:0] rdata;
    logic       scl_lo;
    logic       sda_lo;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic [1:0] sync_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       bus_busy;

  i2c_pin_sync u_sync (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .pin_in  ({scl_in, sda_in}),
    .pin_out (sync_s)
  );

  assign scl_s = sync_s[1];
  assign sda_s = sync_s[0];

  i2c_line_monitor u_mon (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .scl_s     (scl_s),
    .sda_s     (sda_s),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det),
    .bus_busy  (bus_busy)
  );

  // pull data low for a zero bit we send, or for an ack we give
  function automatic logic drive_bit(input logic [3:0] bitn, input logic sh7,
                                     input logic txing, input logic ack_suppress);
    if (bitn < BIT_ACK)
      drive_bit = txing & ~sh7;
    else
      drive_bit = ~txing & ~ack_suppress;
  endfunction : drive_bit

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  logic wr_ctl;
  logic wr_data;
  logic rd_data;
  logic repeat_start_request_w;
  logic lose;
  logic m_txing;
  logic s_txing;
  logic t_done;

  always_comb begin
    s_d     = s_q;
    s_d.rdata = 8'h00;
    lose    = 1'b0;
    wr_ctl  = reg_wr && (reg_addr == OFS_CONTROL);
    wr_data = reg_wr && (reg_addr == OFS_DATA);
    rd_data = reg_rd && (reg_addr == OFS_DATA);
    repeat_start_request_w  = wr_ctl && reg_wdata[CTL_REPEAT_START_REQUEST];
    m_txing = s_q.addr_ph || s_q.tx;
    s_txing = ~s_q.addr_ph && s_q.tx;
    t_done  = (s_q.tmr == 8'h00);
    if (!t_done)
      s_d.tmr = s_q.tmr - 8'h01;

    if (reg_rd) begin
      case (reg_addr)
        OFS_CONTROL:  s_d.rdata = {s_q.en, s_q.ie, s_q.master_select, s_q.tx, s_q.ack_suppress, 3'h0};
        OFS_STATUS:   s_d.rdata = {s_q.transfer_complete_flag, s_q.addressed_as_slave, bus_busy, s_q.arbitration_lost, 1'b0,
                                   s_q.slave_read_write, s_q.interrupt_pending_flag, s_q.received_ack};
        OFS_DATA:     s_d.rdata = s_q.rxd;
        default:      s_d.rdata = s_q.sadr;
      endcase
    end
    if (wr_ctl) begin
      s_d.en   = reg_wdata[CTL_EN];
      s_d.ie   = reg_wdata[CTL_IE];
      s_d.master_select  = reg_wdata[CTL_MST];
      s_d.tx   = reg_wdata[CTL_TX];
      s_d.ack_suppress = reg_wdata[CTL_ACK_SUPPRESS];
      s_d.addressed_as_slave = 1'b0;
    end
    if (reg_wr && (reg_addr == OFS_STATUS)) begin
      if (reg_wdata[ST_ARBITRATION_LOST])
        s_d.arbitration_lost = 1'b0;
      if (reg_wdata[ST_IF])
        s_d.interrupt_pending_flag = 1'b0;
    end
    if (reg_wr && (reg_addr == OFS_SLV_ADDR))
      s_d.sadr = reg_wdata;
    if ((rd_data && !s_q.tx) || (wr_data && s_q.tx))
      s_d.transfer_complete_flag = 1'b0;

    // hardware sets below override the software clears above
    case (s_q.st)
      ST_IDLE: begin
        s_d.scl_lo = 1'b0;
        s_d.sda_lo = 1'b0;
        if (!s_q.mst_prev && s_q.master_select) begin
          s_d.mst_prev = 1'b1;
          if (bus_busy) begin
            lose = 1'b1;
          end else begin
            s_d.st      = ST_MSTART;
            s_d.sda_lo  = 1'b1;
            s_d.tmr     = HALF_RELOAD;
            s_d.addr_ph = 1'b1;
          end
        end else if (start_det) begin
          s_d.st      = ST_SSHIFT;
          s_d.bitn    = 4'h0;
          s_d.addr_ph = 1'b1;
        end
      end
      ST_MSTART: begin
        if (t_done) begin
          s_d.st     = ST_MHOLD;
          s_d.scl_lo = 1'b1;
          s_d.bitn   = 4'h0;
        end
      end
      ST_MLOW: begin
        s_d.sda_lo = drive_bit(s_q.bitn, s_q.sh[7], m_txing, s_q.ack_suppress);
        if (t_done) begin
          s_d.st     = ST_MHIGH;
          s_d.scl_lo = 1'b0;
          s_d.tmr    = HALF_RELOAD;
        end
      end
      ST_MHIGH: begin
        if (!scl_s) begin
          s_d.tmr = HALF_RELOAD; // a slave is stretching the clock
        end else if (m_txing && !s_q.sda_lo && !sda_s && (s_q.bitn < BIT_ACK)) begin
          lose = 1'b1;
        end else if (t_done) begin
          s_d.scl_lo = 1'b1;
          s_d.tmr    = HALF_RELOAD;
          if (s_q.bitn < BIT_ACK) begin
            s_d.sh   = {s_q.sh[6:0], sda_s};
            s_d.bitn = s_q.bitn + 4'h1;
            s_d.st   = ST_MLOW;
          end else begin
            if (m_txing)
              s_d.received_ack = sda_s;
            else
              s_d.rxd = s_q.sh;
            s_d.transfer_complete_flag     = 1'b1;
            s_d.interrupt_pending_flag   = 1'b1;
            s_d.addr_ph = 1'b0;
            s_d.bitn    = 4'h0;
            s_d.sda_lo  = 1'b0;
            s_d.st      = ST_MHOLD;
          end
        end
      end
      ST_MHOLD: begin
        s_d.scl_lo = 1'b1;
        s_d.sda_lo = 1'b0;
        s_d.tmr    = HALF_RELOAD;
        if (s_q.mst_prev && !s_q.master_select) begin
          s_d.mst_prev = 1'b0;
          s_d.sda_lo   = 1'b1;
          s_d.st       = ST_MSTOP1;
        end else if (repeat_start_request_w) begin
          s_d.st = ST_MRS1;
        end else if (wr_data && m_txing) begin
          s_d.sh = reg_wdata;
          s_d.st = ST_MLOW;
        end else if (rd_data && !m_txing) begin
          s_d.st = ST_MLOW;
        end
      end
      ST_MSTOP1: begin
        if (t_done) begin
          s_d.scl_lo = 1'b0;
          s_d.tmr    = HALF_RELOAD;
          s_d.st     = ST_MSTOP2;
        end
      end
      ST_MSTOP2: begin
        if (t_done) begin
          s_d.sda_lo = 1'b0;
          s_d.st     = ST_IDLE;
        end
      end
      ST_MRS1: begin
        if (t_done) begin
          s_d.scl_lo = 1'b0;
          s_d.tmr    = HALF_RELOAD;
          s_d.st     = ST_MRS2;
        end
      end
      ST_MRS2: begin
        if (t_done) begin
          s_d.sda_lo  = 1'b1;
          s_d.tmr     = HALF_RELOAD;
          s_d.addr_ph = 1'b1;
          s_d.st      = ST_MSTART;
        end
      end
      ST_SSHIFT: begin
        if (stop_det) begin
          s_d.sda_lo = 1'b0;
          s_d.st     = ST_IDLE;
        end else if (start_det) begin
          s_d.sda_lo  = 1'b0;
          s_d.bitn    = 4'h0;
          s_d.addr_ph = 1'b1;
        end else if (scl_rise) begin
          if (s_q.bitn < BIT_ACK)
            s_d.sh = {s_q.sh[6:0], sda_s};
          else if (s_txing)
            s_d.received_ack = sda_s;
        end else if (scl_fall) begin
          if (s_q.bitn == BIT_LAST) begin
            s_d.bitn = BIT_ACK;
            if (!s_q.addr_ph) begin
              s_d.sda_lo = drive_bit(BIT_ACK, 1'b0, s_txing, s_q.ack_suppress);
            end else if ((s_q.sh[7:1] == s_q.sadr[7:1]) ||
                         ((s_q.sh == GEN_CALL) && s_q.sadr[SA_GCEN])) begin
              s_d.addressed_as_slave   = 1'b1;
              s_d.slave_read_write    = s_q.sh[0];
              s_d.interrupt_pending_flag  = 1'b1;
              s_d.sda_lo = 1'b1;
            end else begin
              s_d.sda_lo = 1'b0;
              s_d.st     = ST_IDLE;
            end
          end else if (s_q.bitn == BIT_ACK) begin
            s_d.bitn    = 4'h0;
            s_d.sda_lo  = 1'b0;
            s_d.addr_ph = 1'b0;
            if (s_txing && s_q.received_ack) begin
              s_d.st = ST_IDLE; // master ended the read with no ack
            end else begin
              if (!s_txing && !s_q.addr_ph)
                s_d.rxd = s_q.sh;
              s_d.transfer_complete_flag    = 1'b1;
              s_d.interrupt_pending_flag  = 1'b1;
              s_d.scl_lo = 1'b1;
              s_d.st     = ST_SHOLD;
            end
          end else begin
            s_d.bitn   = s_q.bitn + 4'h1;
            s_d.sda_lo = drive_bit(s_q.bitn + 4'h1, s_q.sh[7], s_txing, s_q.ack_suppress);
          end
        end
      end
      ST_SHOLD: begin
        if (stop_det) begin
          s_d.scl_lo = 1'b0;
          s_d.st     = ST_IDLE;
        end else if (wr_data && s_q.tx) begin
          s_d.sh     = reg_wdata;
          s_d.sda_lo = ~reg_wdata[7];
          s_d.scl_lo = 1'b0;
          s_d.st     = ST_SSHIFT;
        end else if (rd_data && !s_q.tx) begin
          s_d.scl_lo = 1'b0;
          s_d.st     = ST_SSHIFT;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase

    // only a current master may repeat a start, and only between bytes
    if (repeat_start_request_w && s_q.master_select && (s_q.st != ST_MHOLD))
      lose = 1'b1;
    if (lose) begin
      s_d.arbitration_lost     = 1'b1;
      s_d.interrupt_pending_flag    = 1'b1;
      s_d.master_select      = 1'b0;
      s_d.mst_prev = 1'b0;
      s_d.scl_lo   = 1'b0;
      s_d.sda_lo   = 1'b0;
      s_d.st       = ST_IDLE;
    end
    if (!s_q.en) begin
      s_d.st       = ST_IDLE;
      s_d.scl_lo   = 1'b0;
      s_d.sda_lo   = 1'b0;
      s_d.mst_prev = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_q      <= '0;
      s_q.st   <= ST_IDLE;
      s_q.en   <= RST_CONTROL[CTL_EN];
      s_q.ie   <= RST_CONTROL[CTL_IE];
      s_q.master_select  <= RST_CONTROL[CTL_MST];
      s_q.tx   <= RST_CONTROL[CTL_TX];
      s_q.ack_suppress <= RST_CONTROL[CTL_ACK_SUPPRESS];
      s_q.transfer_complete_flag  <= RST_TCF;
      s_q.sadr <= RST_SLV_ADDR;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign scl_out   = 1'b0;
  assign sda_out   = 1'b0;
  assign scl_oe    = s_q.scl_lo;
  assign sda_oe    = s_q.sda_lo;
  assign irq       = s_q.interrupt_pending_flag & s_q.ie;

endmodule : i2c_master_slave_controller

`default_nettype wire

// *** i2c_bus_model.sv ***
/*
  Far-side slave model of the two-wire bus: takes bytes, acks or refuses them.
  Assumes the bench resolves the open-drain wires, with pull-ups to 1.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_bus_model (
  input  wire logic       clk_sys,  // sampling clock
  input  wire logic       scl,      // resolved clock line
  input  wire logic       sda,      // resolved data line
  input  wire logic       ack_en,   // answer bytes with ack
  output logic            sda_pull, // pull data line low
  output logic      [7:0] got_byte, // last byte taken
  output var int          got_cnt   // bytes taken
);
  logic       scl_p;
  logic       sda_p;
  logic [7:0] sh;
  int         bitn;

  initial begin
    {scl_p, sda_p, sda_pull, got_byte, sh} = '0;
    got_cnt = 0;
    bitn = -2;
  end

  // ---------------------------------------------------------------
  // framing: -1 after start, 0..7 data bits, 8 ack slot, -2 idle
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    scl_p <= scl;
    sda_p <= sda;
    if (scl && scl_p && sda_p && !sda) begin
      bitn <= -1;
    end else if (scl && scl_p && !sda_p && sda) begin
      bitn <= -2;
      sda_pull <= 1'b0;
    end else if (scl && !scl_p && bitn >= 0 && bitn < 8) begin
      sh <= {sh[6:0], sda};
    end else if (!scl && scl_p) begin
      if (bitn == 7) begin
        // ack pulled and released only while clock is low, so no false start
        sda_pull <= ack_en;
        got_byte <= sh;
        got_cnt <= got_cnt + 1;
        bitn <= 8;
      end else if (bitn == 8) begin
        sda_pull <= 1'b0;
        bitn <= 0;
      end else if (bitn >= -1) begin
        bitn <= bitn + 1;
      end
    end
  end
endmodule : i2c_bus_model

`default_nettype wire

// *** i2c_ctrl_properties.sv ***
/*
  Port-level assertions for the two-wire bus controller.
  Assumes it is bound to the controller top and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_ctrl_properties
  import i2c_ctrl_pkg::*;
(
  input wire logic        clk_sys,   // system clock
  input wire logic        sys_rst,   // reset, high
  input wire logic [1:0]  reg_addr,  // register index
  input wire logic [7:0]  reg_wdata, // write data
  input wire logic        reg_wr,    // write strobe
  input wire logic        reg_rd,    // read strobe
  input wire logic [7:0]  reg_rdata, // read data
  input wire logic        scl_in,    // clock line
  input wire logic        scl_oe,    // clock pull
  input wire logic        sda_in,    // data line
  input wire logic        sda_oe,    // data pull
  input wire logic        irq        // interrupt
);
  logic [7:0]  ctl_q;
  logic        arbitration_lost_q;
  logic        st_ans;
  logic [12:0] stop_cnt;
  wire logic   ctl_wr = reg_wr && reg_addr == OFS_CONTROL;

  // ---------------------------------------------------------------
  // shadow of software-visible state
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctl_q <= RST_CONTROL;
      arbitration_lost_q <= 1'b0;
      st_ans <= 1'b0;
      stop_cnt <= '0;
    end else begin
      st_ans <= reg_rd && reg_addr == OFS_STATUS;
      if (ctl_wr) ctl_q <= reg_wdata;
      if ((reg_wr && reg_addr == OFS_STATUS && reg_wdata[ST_ARBITRATION_LOST]) ||
          (ctl_wr && !reg_wdata[CTL_EN])) arbitration_lost_q <= 1'b0;
      else if (st_ans && reg_rdata[ST_ARBITRATION_LOST]) arbitration_lost_q <= 1'b1;
      // counts while a stop is owed and lines are still pulled
      if (ctl_wr && ctl_q[CTL_MST] && !reg_wdata[CTL_MST] && reg_wdata[CTL_EN]) stop_cnt <= 13'h1;
      else if (stop_cnt != 0 && (scl_oe || sda_oe)) stop_cnt <= stop_cnt + 13'h1;
      else stop_cnt <= '0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_off_released: assert property (ctl_wr && !reg_wdata[CTL_EN] |-> ##[1:3] !(scl_oe || sda_oe))
    else $error("lines driven after disable");
  a_start_made: assert property (ctl_wr && reg_wdata[CTL_EN] && reg_wdata[CTL_MST] &&
    !ctl_q[CTL_MST] && !scl_oe && !sda_oe && scl_in && sda_in |-> ##[1:4] (sda_oe && !scl_oe))
    else $error("no start after master select");
  a_stop_bound: assert property (stop_cnt < 13'd4500)
    else $error("no stop after master select cleared");
  a_ctl_readback: assert property (reg_rd && reg_addr == OFS_CONTROL |=>
    reg_rdata[2:0] == 3'h0 && (reg_rdata & 8'hD8) == (ctl_q & 8'hD8))
    else $error("control read back wrong");
  a_tcf_clear: assert property (reg_wr && reg_addr == OFS_DATA && ctl_q[CTL_TX] ##2
    reg_rd && reg_addr == OFS_STATUS |=> !reg_rdata[ST_TCF])
    else $error("transfer flag not cleared by data write");
  a_addressed_as_slave_clear: assert property (ctl_wr ##2 reg_rd && reg_addr == OFS_STATUS |=>
    !reg_rdata[ST_ADDRESSED_AS_SLAVE])
    else $error("addressed flag survives control write");
  a_arbitration_lost_sticky: assert property (st_ans && arbitration_lost_q |-> reg_rdata[ST_ARBITRATION_LOST])
    else $error("arbitration flag lost without write one");
  a_irq_flag: assert property (st_ans |->
    $past(irq) == (reg_rdata[ST_IF] && $past(ctl_q[CTL_IE])))
    else $error("interrupt out differs from flag and enable");

  c_start: cover property ($rose(sda_oe) && !scl_oe);
  c_flag: cover property (st_ans && reg_rdata[ST_IF]);
  c_arbitration_lost: cover property (st_ans && reg_rdata[ST_ARBITRATION_LOST]);
endmodule : i2c_ctrl_properties

bind i2c_master_slave_controller i2c_ctrl_properties i_props (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_in),
  .scl_oe(scl_oe), .sda_in(sda_in), .sda_oe(sda_oe), .irq(irq)
);

`default_nettype wire

// *** i2c_master_slave_controller_tb.sv ***
/*
  Self-checking bench: master writes to a far-side slave model, stop,
  misplaced repeat start, disable. Assumes the 200-cycle bit half period.
*/
`timescale 1ns/1ps
`default_nettype none

module i2c_master_slave_controller_tb;
  import i2c_ctrl_pkg::*;
  localparam logic [7:0] TRANSFER_COMPLETE_FLAG = 8'(1 << ST_TCF);
  localparam logic [7:0] BSY = 8'(1 << ST_BUSY);
  localparam logic [7:0] ARB = 8'(1 << ST_ARBITRATION_LOST);
  localparam logic [7:0] IFL = 8'(1 << ST_IF);
  localparam logic [7:0] RXK = 8'(1 << ST_RECEIVED_ACK);
  logic       clk_sys, sys_rst, reg_wr, reg_rd, ack_en, scl_out, scl_oe, sda_out, sda_oe;
  logic       irq, sda_pull;
  logic [1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, got_byte, rv, b;
  int         got_cnt, err_total, num_checks, cyc;
  integer     seed;
  logic [7:0] sent_q[$];
  wire logic  scl_w = !scl_oe;
  wire logic  sda_w = !(sda_oe || sda_pull);

  i2c_master_slave_controller i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_in(scl_w),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out),
    .sda_oe(sda_oe), .irq(irq)
  );
  i2c_bus_model i_model (
    .clk_sys(clk_sys), .scl(scl_w), .sda(sda_w), .ack_en(ack_en),
    .sda_pull(sda_pull), .got_byte(got_byte), .got_cnt(got_cnt)
  );

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d, mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    rd(OFS_STATUS, rv);
    chk("status", e & m, rv & m);
  endtask : st
  task automatic send(input logic [7:0] d);
    wr(OFS_DATA, d);
    sent_q.push_back(d);
  endtask : send
  // polls the flag; a byte takes some 3600 cycles
  task automatic wait_byte;
    int n;
    n = 0;
    rv = 8'h00;
    while (rv[ST_TCF] !== 1'b1 && n < 400) begin
      repeat (20) @(posedge clk_sys);
      rd(OFS_STATUS, rv);
      n++;
    end
    chk("bus byte", sent_q.pop_front(), got_byte);
  endtask : wait_byte

  // ---------------------------------------------------------------
  // clock, timeout, sequence
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out;
    end
  end
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    sys_rst = 1'b1;
    ack_en = 1'b1;
    seed = 19;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(OFS_CONTROL, rv);
    chk("control", RST_CONTROL, rv);
    st(8'hFF, TRANSFER_COMPLETE_FLAG);
    wr(OFS_CONTROL, 8'hF0);
    repeat (300) @(posedge clk_sys);
    st(8'hFF, TRANSFER_COMPLETE_FLAG | BSY);
    rd(OFS_CONTROL, rv);
    chk("control", 8'hF0, rv);
    send(8'($random(seed)) & 8'hFE);
    st(8'hFF, BSY);
    wait_byte;
    st(8'hFF, TRANSFER_COMPLETE_FLAG | BSY | IFL);
    chk("irq", 8'h01, {7'h0, irq});
    wr(OFS_STATUS, IFL);
    st(8'hFF, TRANSFER_COMPLETE_FLAG | BSY);
    chk("irq", 8'h00, {7'h0, irq});
    ack_en <= 1'b0;
    send(8'($random(seed)));
    wait_byte;
    st(8'hFF, TRANSFER_COMPLETE_FLAG | BSY | IFL | RXK);
    wr(OFS_CONTROL, 8'hD0);
    st(8'h40, 8'h00);
    repeat (800) @(posedge clk_sys);
    chk("lines", 8'h03, {6'h0, scl_w, sda_w});
    st(BSY, 8'h00);
    ack_en <= 1'b1;
    // master read: released line gives all ones
    wr(OFS_CONTROL, 8'hF0);
    repeat (300) @(posedge clk_sys);
    send(8'($random(seed)) | 8'h01);
    wait_byte;
    wr(OFS_CONTROL, 8'hE0);
    rd(OFS_DATA, rv);
    sent_q.push_back(8'hFF);
    wait_byte;
    st(TRANSFER_COMPLETE_FLAG | RXK, TRANSFER_COMPLETE_FLAG);
    wr(OFS_CONTROL, 8'hC0);
    rd(OFS_DATA, rv);
    chk("rx data", 8'hFF, rv);
    repeat (800) @(posedge clk_sys);
    wr(OFS_CONTROL, 8'hF0);
    repeat (300) @(posedge clk_sys);
    b = 8'($random(seed)) & 8'hFE;
    wr(OFS_DATA, b);
    repeat (100) @(posedge clk_sys);
    wr(OFS_CONTROL, 8'hF4);
    repeat (20) @(posedge clk_sys);
    st(ARB | IFL, ARB | IFL);
    wr(OFS_STATUS, 8'h00);
    st(ARB, ARB);
    wr(OFS_STATUS, ARB);
    st(ARB, 8'h00);
    wr(OFS_CONTROL, 8'h00);
    repeat (10) @(posedge clk_sys);
    chk("line pulls", 8'h00, {6'h0, scl_oe, sda_oe});
    close_out;
  end
endmodule : i2c_master_slave_controller_tb

`default_nettype wire
